// ===== include/gfr_pkg.sv
`default_nettype none
package gfr_pkg;
  // ==========================================================
  // Register map, word offsets on the bus
  // ==========================================================
  localparam logic [7:0] GFR_OFS_STATUS = 8'h00;
  localparam logic [7:0] GFR_OFS_FAULT_ADDRESS_FIELD_LO = 8'h04;
  localparam logic [7:0] GFR_OFS_FAULT_ADDRESS_FIELD_HI = 8'h08;
  localparam logic [7:0] GFR_OFS_XLAT = 8'h0c;
  localparam logic [7:0] GFR_OFS_ALIAS = 8'h10;
  localparam logic [7:0] GFR_OFS_END = 8'h20;
  // ==========================================================
  // Fault status bit positions
  // ==========================================================
  localparam int GFR_BIT_INV_CTX = 0;
  localparam int GFR_BIT_UNID_STREAM = 1;
  localparam int GFR_BIT_MATCH_CONFLICT = 2;
  localparam int GFR_BIT_UNIMP_BANK = 3;
  localparam int GFR_BIT_UNIMP_IRQ = 4;
  localparam int GFR_BIT_CFG_ACCESS = 5;
  localparam int GFR_BIT_EXT_ABORT = 6;
  localparam int GFR_BIT_PERM = 7;
  localparam int GFR_BIT_UNSUP_UP = 8;
  localparam int GFR_BIT_MULTI = 31;
  localparam int GFR_XLAT_ACTIVE_BIT = 0;
  localparam int GFR_NUM_KINDS = 9;
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [31:0] GFR_RST_STATUS = 32'h0000_0000;
  localparam logic [63:0] GFR_RST_FAULT_ADDRESS_FIELD = 64'h0;
  localparam logic GFR_RST_ACTIVE = 1'b0;
  // ==========================================================
  // Fault classes, value is the status bit it sets
  // ==========================================================
  typedef enum logic [3:0] {
    GFR_K_INV_CTX = 4'h0,
    GFR_K_UNID_STREAM = 4'h1,
    GFR_K_MATCH_CONFLICT = 4'h2,
    GFR_K_UNIMP_BANK = 4'h3,
    GFR_K_UNIMP_IRQ = 4'h4,
    GFR_K_CFG_ACCESS = 4'h5,
    GFR_K_EXT_ABORT = 4'h6,
    GFR_K_PERM = 4'h7,
    GFR_K_UNSUP_UP = 4'h8
  } gfr_kind_t;
endpackage
`default_nettype wire

// ===== logic/gfr_bank.sv
`default_nettype none
module gfr_bank
  import gfr_pkg::*;
#(
  parameter bit SECURE = 1'b0,
  parameter bit ARCH_V2 = 1'b1,
  parameter int FAULT_ADDRESS_FIELD_W = 40,
  parameter bit HAS_EF = 1'b1,
  parameter bit HAS_CAF = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [GFR_NUM_KINDS-1:0] flt_set,
  input wire logic [63:0] flt_addr,
  input wire logic clr_we,
  input wire logic [31:0] clr_bits,
  input wire logic fault_address_field_we_lo,
  input wire logic fault_address_field_we_hi,
  input wire logic [31:0] wmask,
  input wire logic [31:0] wdata,
  input wire logic xlat_start,
  input wire logic xlat_done,
  output logic [31:0] status,
  output logic [63:0] fault_address_field,
  output logic active
);
  // ==========================================================
  // Implemented bits
  // ==========================================================
  function automatic logic [31:0] impl_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    m[GFR_BIT_MULTI] = 1'b1;
    m[GFR_BIT_UNIMP_IRQ:GFR_BIT_INV_CTX] = 5'h1f;
    m[GFR_BIT_UNSUP_UP] = ARCH_V2;
    m[GFR_BIT_PERM] = SECURE;
    m[GFR_BIT_EXT_ABORT] = HAS_EF;
    m[GFR_BIT_CFG_ACCESS] = HAS_CAF;
    return m;
  endfunction

  localparam logic [31:0] IMPL = impl_mask();
  // Upper address bits read as zero
  localparam logic [63:0] AMASK = 64'(({64'h0, 1'b1} << FAULT_ADDRESS_FIELD_W) - 65'h1);

  typedef struct packed {
    logic [31:0] status;
    logic [63:0] fault_address_field;
    logic active;
  } gfr_bank_st_t;

  gfr_bank_st_t st_r;
  gfr_bank_st_t st_nxt;
  logic [31:0] set_v;
  logic new_err;

  always_comb
  begin
    st_nxt = st_r;
    // A fault class this bank does not implement is no error at all
    set_v = {23'h0, flt_set} & IMPL;
    new_err = |set_v;
    if (new_err && (st_r.status != 32'h0))
    begin
      set_v[GFR_BIT_MULTI] = 1'b1;
    end
    // A fault in the clearing cycle survives: set is applied after clear
    if (clr_we)
    begin
      st_nxt.status = st_r.status & ~clr_bits;
    end
    st_nxt.status = (st_nxt.status | set_v) & IMPL;
    if (fault_address_field_we_lo)
    begin
      st_nxt.fault_address_field[31:0] = (st_r.fault_address_field[31:0] & ~wmask) | (wdata & wmask);
    end
    if (fault_address_field_we_hi)
    begin
      st_nxt.fault_address_field[63:32] = (st_r.fault_address_field[63:32] & ~wmask) | (wdata & wmask);
    end
    // Only the first fault is described; later ones set their own bit and the multiple flag
    if (new_err && (st_r.status == 32'h0))
    begin
      st_nxt.fault_address_field = flt_addr;
    end
    st_nxt.fault_address_field = st_nxt.fault_address_field & AMASK;
    if (xlat_start && !st_r.active)
    begin
      st_nxt.active = 1'b1;
    end
    else if (xlat_done)
    begin
      st_nxt.active = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '{GFR_RST_STATUS, GFR_RST_FAULT_ADDRESS_FIELD, GFR_RST_ACTIVE};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign fault_address_field = st_r.fault_address_field;
  assign active = st_r.active;
endmodule
`default_nettype wire

// ===== logic/gfr_top.sv
// How it works
// - Active flag high until result written
// - Capture faulting input address, upper bits zero
// - Config access fault records register-space offset
// - Newer architecture: width equals upstream bus size
// - Older architecture: width 32, 36 or 40
// - Writing one clears a status bit
// - Reset contents are not to be relied on
// - Error while status nonzero sets multiple flag
// - Bit 8 flags unsupported upstream transactions
// - Bit 7 permission fault only in secure bank
// - Context-bank faults go to that bank
// - Bit 6 flags external abort, optional
// - Bit 5 flags config access fault, optional
// - Flags for unimplemented interrupt and bank faults
// - Flags for match conflict and unidentified stream
// - Flag for invalid context fault
// - Banked per security state, secure alias
`default_nettype none
module gfr_top
  import gfr_pkg::*;
#(
  parameter bit ARCH_V2 = 1'b1,
  parameter int FAULT_ADDRESS_FIELD_W = 40,
  parameter bit HAS_EF = 1'b1,
  parameter bit HAS_CAF = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_sec_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic flt_valid,
  input wire logic [3:0] flt_kind,
  input wire logic flt_secure,
  input wire logic flt_ctx_valid,
  input wire logic [7:0] flt_ctx_bank,
  input wire logic [63:0] flt_addr,
  input wire logic [63:0] flt_cfg_offset,
  input wire logic xlat_start,
  input wire logic xlat_start_secure,
  input wire logic xlat_done,
  input wire logic xlat_done_secure,
  output logic ctx_flt_valid,
  output logic [7:0] ctx_flt_bank,
  output logic [3:0] ctx_flt_kind,
  output logic [63:0] ctx_flt_addr,
  output logic [1:0] gflt_pending
);
  // ==========================================================
  // Configuration checks
  // ==========================================================
  generate
    if (ARCH_V2 && (FAULT_ADDRESS_FIELD_W < 1 || FAULT_ADDRESS_FIELD_W > 64))
    begin : g_chk_v2
      $error("gfr_top: FAULT_ADDRESS_FIELD_W must be 1 to 64");
    end
    if (!ARCH_V2 && FAULT_ADDRESS_FIELD_W != 32 && FAULT_ADDRESS_FIELD_W != 36 && FAULT_ADDRESS_FIELD_W != 40)
    begin : g_chk_v1
      $error("gfr_top: FAULT_ADDRESS_FIELD_W must be 32, 36 or 40");
    end
  endgenerate

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic cvalid;
    logic [7:0] cbank;
    logic [3:0] ckind;
    logic [63:0] caddr;
    logic [1:0] pend;
  } gfr_top_st_t;

  gfr_top_st_t st_r;
  gfr_top_st_t st_nxt;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic req;
  logic is_alias;
  logic mapped;
  logic bsel;
  logic [7:0] word_ofs;
  logic [31:0] bmask;
  logic do_wr;

  assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
  // Alias window reaches the non-secure copy, secure masters only
  assign is_alias = (wb_adr_i >= GFR_OFS_ALIAS) && (wb_adr_i < GFR_OFS_END);
  assign mapped = (wb_adr_i < GFR_OFS_ALIAS) || (is_alias && wb_sec_i);
  assign bsel = is_alias ? 1'b0 : wb_sec_i;
  assign word_ofs = {wb_adr_i[7:2] & 6'h03, 2'b00};
  assign do_wr = req && wb_we_i && mapped;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign bmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // ==========================================================
  // Fault routing
  // ==========================================================
  logic glob_flt;
  logic [GFR_NUM_KINDS-1:0] kind_vec;
  logic [63:0] rec_addr;

  // Faults tied to a translation context bank bypass the global record
  assign glob_flt = flt_valid && !flt_ctx_valid;
  assign kind_vec = GFR_NUM_KINDS'(1) << flt_kind;
  assign rec_addr = (flt_kind == GFR_K_CFG_ACCESS) ? flt_cfg_offset : flt_addr;

  // ==========================================================
  // Per security state banks
  // ==========================================================
  logic [1:0][31:0] bk_status;
  logic [1:0][63:0] bk_fault_address_field;
  logic [1:0] bk_active;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_bank
      localparam bit SEC = (gi == 1);
      logic mine;
      logic flt_here;
      assign mine = (bsel == SEC) && do_wr;
      assign flt_here = glob_flt && (flt_secure == SEC);
      gfr_bank #(
        .SECURE(SEC),
        .ARCH_V2(ARCH_V2),
        .FAULT_ADDRESS_FIELD_W(FAULT_ADDRESS_FIELD_W),
        .HAS_EF(HAS_EF),
        .HAS_CAF(HAS_CAF)
      ) u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .flt_set(flt_here ? kind_vec : {GFR_NUM_KINDS{1'b0}}),
        .flt_addr(rec_addr),
        .clr_we(mine && word_ofs == GFR_OFS_STATUS),
        .clr_bits(wb_dat_i & bmask),
        .fault_address_field_we_lo(mine && word_ofs == GFR_OFS_FAULT_ADDRESS_FIELD_LO),
        .fault_address_field_we_hi(mine && word_ofs == GFR_OFS_FAULT_ADDRESS_FIELD_HI),
        .wmask(bmask),
        .wdata(wb_dat_i),
        .xlat_start(xlat_start && (xlat_start_secure == SEC)),
        .xlat_done(xlat_done && (xlat_done_secure == SEC)),
        .status(bk_status[gi]),
        .fault_address_field(bk_fault_address_field[gi]),
        .active(bk_active[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    st_nxt = st_r;
    // Ack lasts one cycle; a held request is answered again in the cycle after ack drops
    st_nxt.ack = req;
    if (req && !wb_we_i)
    begin
      st_nxt.dat = 32'h0000_0000;
      if (!mapped)
      begin
        st_nxt.dat = 32'h0000_0000;
      end
      else if (word_ofs == GFR_OFS_STATUS)
      begin
        st_nxt.dat = bk_status[bsel];
      end
      else if (word_ofs == GFR_OFS_FAULT_ADDRESS_FIELD_LO)
      begin
        st_nxt.dat = bk_fault_address_field[bsel][31:0];
      end
      else if (word_ofs == GFR_OFS_FAULT_ADDRESS_FIELD_HI)
      begin
        st_nxt.dat = bk_fault_address_field[bsel][63:32];
      end
      else
      begin
        st_nxt.dat[GFR_XLAT_ACTIVE_BIT] = bk_active[bsel];
      end
    end
    st_nxt.cvalid = flt_valid && flt_ctx_valid;
    if (flt_valid && flt_ctx_valid)
    begin
      st_nxt.cbank = flt_ctx_bank;
      st_nxt.ckind = flt_kind;
      st_nxt.caddr = rec_addr;
    end
    st_nxt.pend[0] = bk_status[0] != 32'h0;
    st_nxt.pend[1] = bk_status[1] != 32'h0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign ctx_flt_valid = st_r.cvalid;
  assign ctx_flt_bank = st_r.cbank;
  assign ctx_flt_kind = st_r.ckind;
  assign ctx_flt_addr = st_r.caddr;
  assign gflt_pending = st_r.pend;
endmodule
`default_nettype wire

// ===== tb/gfr_asserts.sv
`default_nettype none
// ======
// Port-level checks
// ======
module gfr_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic flt_valid,
  input wire logic [3:0] flt_kind,
  input wire logic flt_secure,
  input wire logic flt_ctx_valid,
  input wire logic ctx_flt_valid,
  input wire logic [1:0] gflt_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_ctx_fwd;
    flt_valid && flt_ctx_valid |=> ctx_flt_valid;
  endproperty
  a_ctx_fwd: assert property (p_ctx_fwd) else $error("ctx not sent");
  property p_ctx_cause;
    ctx_flt_valid |-> $past(flt_valid && flt_ctx_valid);
  endproperty
  a_ctx_cause: assert property (p_ctx_cause) else $error("stray ctx");
  property p_ns_pend;
    flt_valid && !flt_ctx_valid && !flt_secure && flt_kind < 4'h5 |-> ##2 gflt_pending[0];
  endproperty
  a_ns_pend: assert property (p_ns_pend) else $error("ns flag lost");
  property p_s_pend;
    flt_valid && !flt_ctx_valid && flt_secure && (flt_kind < 4'h5 || flt_kind == 4'h7)
      |-> ##2 gflt_pending[1];
  endproperty
  a_s_pend: assert property (p_s_pend) else $error("s flag lost");
  // Pending lags status by a cycle, so the bus cycle before must be idle as well as this one
  property p_hold;
    gflt_pending[0] && !wb_cyc_i && !$past(wb_cyc_i) |=> gflt_pending[0];
  endproperty
  a_hold: assert property (p_hold) else $error("status lost");
endmodule
bind gfr_top gfr_asserts u_gfr_asserts (.*);
`default_nettype wire

// ===== tb/tb_gfr_top.sv
`default_nettype none
module tb_gfr_top
  import gfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] AMASK = 64'h0000_00ff_ffff_ffff;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_sec_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, flt_ctx_bank = 8'h00, ctx_flt_bank;
  logic [3:0] wb_sel_i = 4'h0, flt_kind = 4'h0, ctx_flt_kind;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic flt_valid = 1'b0, flt_secure = 1'b0, flt_ctx_valid = 1'b0;
  logic xlat_start = 1'b0, xlat_start_secure = 1'b0;
  logic xlat_done = 1'b0, xlat_done_secure = 1'b0;
  logic [63:0] flt_addr = 64'h0, flt_cfg_offset = 64'h0, ctx_flt_addr;
  logic wb_ack_o, ctx_flt_valid;
  logic [1:0] gflt_pending;
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  gfr_top dut (.*);
  // ======
  // Helpers
  // ======
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, input logic sec);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    wb_sec_i <= sec;
    // Waits for the answer however long; only the watchdog ends a hang
    @(posedge clk);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sec);
    bus(1'b1, a, 4'hf, d, sec);
  endtask
  task automatic rd(input logic [7:0] a, input logic sec, input logic [31:0] e, string nm);
    bus(1'b0, a, 4'h0, 32'h0, sec);
    chk(nm, q, e);
  endtask
  // The config offset is the inverted address so the two are told apart
  task automatic fault(input logic [3:0] k, input logic sec, input logic ctx,
    input logic [63:0] ad);
    @(posedge clk);
    flt_valid <= 1'b1;
    flt_kind <= k;
    flt_secure <= sec;
    flt_ctx_valid <= ctx;
    flt_addr <= ad;
    flt_cfg_offset <= ~ad;
    flt_ctx_bank <= 8'h05;
    @(posedge clk);
    flt_valid <= 1'b0;
  endtask
  // ======
  // Scenarios
  // ======
  task automatic t_kinds();
    logic [63:0] a, e;
    logic [31:0] b;
    for (int k = 0; k < 9; k++)
    begin
      a = 64'hfedc_ba98_7654_3200 + k;
      e = ((k == 5) ? ~a : a) & AMASK;
      b = (k == 7) ? 32'h0 : 32'h1 << k;
      wr(GFR_OFS_STATUS, 32'hffff_ffff, 1'b0);
      fault(k[3:0], 1'b0, 1'b0, a);
      rd(GFR_OFS_STATUS, 1'b0, b, "status");
      chk("pend", gflt_pending, {1'b0, b != 0});
      if (k != 7)
      begin
        rd(GFR_OFS_FAULT_ADDRESS_FIELD_LO, 1'b0, e[31:0], "fault_address_field_lo");
        rd(GFR_OFS_FAULT_ADDRESS_FIELD_HI, 1'b0, e[63:32], "fault_address_field_hi");
      end
    end
    $display("kinds done");
  endtask
  task automatic t_multi();
    wr(GFR_OFS_STATUS, 32'hffff_ffff, 1'b0);
    fault(4'h2, 1'b0, 1'b0, 64'h1000);
    fault(4'h1, 1'b0, 1'b0, 64'h2000);
    rd(GFR_OFS_STATUS, 1'b0, 32'h8000_0006, "multi");
    rd(GFR_OFS_FAULT_ADDRESS_FIELD_LO, 1'b0, 32'h1000, "first");
    wr(GFR_OFS_STATUS, 32'h0000_0002, 1'b0);
    rd(GFR_OFS_STATUS, 1'b0, 32'h8000_0004, "w1c");
    wr(GFR_OFS_STATUS, 32'hffff_ffff, 1'b0);
    rd(GFR_OFS_STATUS, 1'b0, 32'h0, "clr");
    $display("multi done");
  endtask
  task automatic t_banks();
    fault(4'h7, 1'b1, 1'b0, 64'h3000);
    rd(GFR_OFS_STATUS, 1'b1, 32'h80, "s");
    chk("s_pend", gflt_pending[1], 1'b1);
    rd(GFR_OFS_STATUS, 1'b0, 32'h0, "ns");
    fault(4'h0, 1'b0, 1'b0, 64'h4000);
    rd(GFR_OFS_ALIAS, 1'b1, 32'h1, "alias");
    rd(GFR_OFS_ALIAS, 1'b0, 32'h0, "alias_ns");
    rd(GFR_OFS_END, 1'b0, 32'h0, "unmapped");
    wr(GFR_OFS_STATUS, 32'hffff_ffff, 1'b1);
    wr(GFR_OFS_ALIAS, 32'hffff_ffff, 1'b1);
    rd(GFR_OFS_STATUS, 1'b0, 32'h0, "alias_clr");
    rd(GFR_OFS_STATUS, 1'b1, 32'h0, "s_clr");
    chk("s_pend_clr", gflt_pending[1], 1'b0);
    $display("banks done");
  endtask
  task automatic t_ctx();
    fault(4'h3, 1'b0, 1'b1, 64'h5000);
    #1;
    chk("ctx_v", ctx_flt_valid, 1'b1);
    chk("ctx_b", ctx_flt_bank, 8'h05);
    chk("ctx_k", ctx_flt_kind, 4'h3);
    chk("ctx_a", ctx_flt_addr, 64'h5000);
    rd(GFR_OFS_STATUS, 1'b0, 32'h0, "ctx_g");
    $display("ctx done");
  endtask
  task automatic t_xlat();
    @(posedge clk);
    xlat_start <= 1'b1;
    @(posedge clk);
    xlat_start <= 1'b0;
    rd(GFR_OFS_XLAT, 1'b0, 32'h1, "active");
    rd(GFR_OFS_XLAT, 1'b1, 32'h0, "s_idle");
    @(posedge clk);
    xlat_done <= 1'b1;
    @(posedge clk);
    xlat_done <= 1'b0;
    rd(GFR_OFS_XLAT, 1'b0, 32'h0, "idle");
    @(posedge clk);
    xlat_start <= 1'b1;
    xlat_start_secure <= 1'b1;
    @(posedge clk);
    xlat_start <= 1'b0;
    rd(GFR_OFS_XLAT, 1'b1, 32'h1, "s_active");
    rd(GFR_OFS_ALIAS + 8'h0c, 1'b1, 32'h0, "ns_idle");
    @(posedge clk);
    xlat_done <= 1'b1;
    xlat_done_secure <= 1'b1;
    @(posedge clk);
    xlat_done <= 1'b0;
    rd(GFR_OFS_XLAT, 1'b1, 32'h0, "s_done");
    $display("xlat done");
  endtask
  task automatic t_fault_address_field();
    wr(GFR_OFS_FAULT_ADDRESS_FIELD_HI, 32'hffff_ffff, 1'b0);
    rd(GFR_OFS_FAULT_ADDRESS_FIELD_HI, 1'b0, 32'h0000_00ff, "raz");
    wr(GFR_OFS_FAULT_ADDRESS_FIELD_LO, 32'h0, 1'b0);
    bus(1'b1, GFR_OFS_FAULT_ADDRESS_FIELD_LO, 4'h3, 32'haaaa_5555, 1'b0);
    rd(GFR_OFS_FAULT_ADDRESS_FIELD_LO, 1'b0, 32'h0000_5555, "sel");
    $display("fault_address_field done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(GFR_OFS_STATUS, 1'b0, 32'h0, "rst");
    t_kinds();
    t_multi();
    t_banks();
    t_ctx();
    t_xlat();
    t_fault_address_field();
    summarize();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
